// ### rtl/clock_generator_unit.sv
// Clock generator unit: source selection, reference and bus dividers,
// internal reference gating, stop retention, lock and clock monitors.
// Assumes all clocks arrive as one-cycle tick enables on MCLK.
//
// Functional notes
// - Source code 00 loop output, 01 internal, 10 external reference
// - Source code 11 behaves as 00
// - Reference divider codes 000 to 011 divide by 1,2,4,8; resets 000
// - Reference codes 110 and 111 divide by 64 and 128
// - Reference select bit 2 picks internal when set, external when clear
// - Internal reference output runs only while its enable bit is set
// - Stop enable keeps internal reference in stop if enabled or internal mode
// - Stop enable clear turns internal reference off in stop
// - Nine operating modes including stop are tracked
// - Selected source passes through a divide by 1,2,4,8 bus divider
// - Debug clock is oscillator core divided by exactly 2
// - No pins leave the chip; all ports are internal
// - External reference monitored; failure requests a reset
// - Lock detector status can raise an interrupt request
// - Nine software-written trim bits adjust internal reference period
// - Loop reference is internal or external by reference select
// - Bus divider field codes 00 to 11, reset 01
// - Sticky lock loss flag cleared by reset or writing 1
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module clock_generator_unit
   import clock_generator_unit_pkg::*;
(
   // Clock and reset
   input  wire logic              MCLK,
   input  wire logic              RST,
   // APB slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // Source ticks and loop status
   input  wire logic              INT_REF_TICK,
   input  wire logic              EXT_REF_TICK,
   input  wire logic              DCO_TICK,
   input  wire logic              LOOP_LOCKED,
   input  wire logic              STOP_REQ,
   // Clock enables to the system
   output logic                   SYS_CLK_EN,
   output logic                   DEBUG_CLK_OUT,
   output logic                   INT_REF_OUT,
   output logic                   REF_DIV_TICK,
   // Analog steering and requests
   output logic                   INT_REF_RUN,
   output logic [TRIM_W-1:0]      TRIM,
   output logic                   PLL_SELECT,
   output logic                   LOOP_ENABLE,
   output logic                   LOSS_RESET_REQ,
   output logic                   LOCK_IRQ
);
   logic [7:0]           ctrl1_q, ctrl2_q, ctrl3_q;
   logic [TRIM_W-1:0]    trim_q;
   logic                 lock_loss_q, locked_q, ext_lost_q;
   logic [MON_CNT_W-1:0] mon_cnt_q;
   mode_e                mode_q, prestop_q, mode_d;
   logic                 int_run_q, int_out_q, dbg_phase_q, dbg_q, loop_en_q;
   logic                 pready_q, pslverr_q;
   logic [31:0]          prdata_q, rdata;
   logic                 rd_hit, wr_en, w1c_lock, w1c_ext, lock_event, mon_expire;
   logic [1:0]           src_sel, src_eff;
   logic                 ref_sel, int_out_en, int_stop_en, low_power;
   logic                 pll_sel, lock_det_en, lock_ie, mon_en, ext_in_use;

   tick_div_if ref_div ();
   tick_div_if bus_div ();

   assign src_sel     = ctrl1_q[SRC_SEL_LSB +: 2];
   assign ref_sel     = ctrl1_q[REF_SEL_BIT];
   assign int_out_en  = ctrl1_q[INT_OUT_EN_BIT];
   assign int_stop_en = ctrl1_q[INT_STOP_EN_BIT];
   assign low_power   = ctrl2_q[LOW_POWER_BIT];
   assign pll_sel     = ctrl3_q[PLL_SEL_BIT];
   assign lock_det_en = ctrl3_q[LOCK_DET_BIT];
   assign lock_ie     = ctrl3_q[LOCK_IE_BIT];
   assign mon_en      = ctrl3_q[MON_EN_BIT];
   assign src_eff     = (src_sel == SRC_RSVD) ? SRC_LOOP : src_sel;

   // ------------------------------------------------------------------
   // Operating mode
   // ------------------------------------------------------------------
   always_comb begin
      mode_d = fll_engaged_int_mode;
      if (STOP_REQ) begin
         mode_d = stop_mode;
      end else begin
         case (src_eff)
            SRC_LOOP: mode_d = ref_sel ? fll_engaged_int_mode :
                               (pll_sel ? pll_engaged_ext_mode : fll_engaged_ext_mode);
            SRC_INT:  mode_d = low_power ? lowpower_int_mode : fll_bypassed_int_mode;
            SRC_EXT:  mode_d = low_power ? lowpower_ext_mode :
                               (pll_sel ? pll_bypassed_ext_mode : fll_bypassed_ext_mode);
            default:  mode_d = fll_engaged_int_mode;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         mode_q    <= fll_engaged_int_mode;
         prestop_q <= fll_engaged_int_mode;
         loop_en_q <= 1'b1;
      end else begin
         mode_q <= mode_d;
         if (mode_q != stop_mode) begin
            prestop_q <= mode_q;
         end
         // Low power shuts the loop only while it is bypassed
         loop_en_q <= !STOP_REQ && !(low_power && src_eff != SRC_LOOP);
      end
   end

   // ------------------------------------------------------------------
   // Reference and bus dividers
   // ------------------------------------------------------------------
   assign ref_div.tick_in    = ref_sel ? INT_REF_TICK : EXT_REF_TICK;
   assign ref_div.log2_ratio = ctrl1_q[REF_DIV_LSB +: 3];

   always_comb begin
      bus_div.tick_in = 1'b0;
      if (!STOP_REQ) begin
         case (src_eff)
            SRC_LOOP: bus_div.tick_in = DCO_TICK;
            SRC_INT:  bus_div.tick_in = INT_REF_TICK;
            SRC_EXT:  bus_div.tick_in = EXT_REF_TICK;
            default:  bus_div.tick_in = DCO_TICK;
         endcase
      end
   end
   assign bus_div.log2_ratio = {1'b0, ctrl2_q[BUS_DIV_LSB +: 2]};

   tick_divider #(.CNT_W(7)) u_ref_div (.MCLK(MCLK), .RST(RST), .dv(ref_div));
   tick_divider #(.CNT_W(3)) u_bus_div (.MCLK(MCLK), .RST(RST), .dv(bus_div));

   // ------------------------------------------------------------------
   // Internal reference gating, stop retention, debug clock
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         int_run_q   <= 1'b1;
         int_out_q   <= 1'b0;
         dbg_phase_q <= 1'b0;
         dbg_q       <= 1'b0;
      end else begin
         if (!STOP_REQ) begin
            int_run_q <= 1'b1;
         end else begin
            int_run_q <= int_stop_en && (int_out_en
                         || prestop_q == fll_engaged_int_mode
                         || prestop_q == fll_bypassed_int_mode
                         || prestop_q == lowpower_int_mode);
         end
         int_out_q <= INT_REF_TICK && int_out_en && int_run_q;
         if (DCO_TICK) begin
            dbg_phase_q <= !dbg_phase_q;
         end
         dbg_q <= DCO_TICK && dbg_phase_q;
      end
   end

   // ------------------------------------------------------------------
   // Lock detector and external clock monitor
   // ------------------------------------------------------------------
   assign lock_event = lock_det_en && locked_q && !LOOP_LOCKED;
   assign ext_in_use = mon_en && !ref_sel | (mon_en && src_eff == SRC_EXT);
   assign mon_expire = mon_cnt_q == MON_CNT_W'(MON_TIMEOUT_CYC - 1);

   always_ff @(posedge MCLK) begin
      if (RST) begin
         locked_q    <= 1'b0;
         lock_loss_q <= 1'b0;
      end else begin
         locked_q <= lock_det_en && LOOP_LOCKED;
         // A new loss event wins over a software clear
         if (lock_event) begin
            lock_loss_q <= 1'b1;
         end else if (w1c_lock) begin
            lock_loss_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         mon_cnt_q  <= '0;
         ext_lost_q <= 1'b0;
      end else begin
         if (EXT_REF_TICK || !ext_in_use || STOP_REQ || mon_expire) begin
            mon_cnt_q <= '0;
         end else begin
            mon_cnt_q <= mon_cnt_q + MON_CNT_W'(1);
         end
         if (mon_expire && ext_in_use && !EXT_REF_TICK && !STOP_REQ) begin
            ext_lost_q <= 1'b1;
         end else if (w1c_ext) begin
            ext_lost_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // APB slave: one wait cycle, answer registered
   // ------------------------------------------------------------------
   assign wr_en    = PSEL && PENABLE && PWRITE && pready_q && !pslverr_q;
   assign w1c_lock = wr_en && PADDR == OFF_STATUS && PWDATA[LOCK_LOSS_BIT] && lock_loss_q;
   assign w1c_ext  = wr_en && PADDR == OFF_STATUS && PWDATA[EXT_LOST_BIT];

   always_comb begin
      rdata  = 32'h0;
      rd_hit = 1'b1;
      case (PADDR)
         OFF_CTRL1:  rdata = {24'h0, ctrl1_q};
         OFF_CTRL2:  rdata = {24'h0, ctrl2_q};
         OFF_TRIM:   rdata = {23'h0, trim_q};
         OFF_CTRL3:  rdata = {24'h0, ctrl3_q};
         OFF_STATUS: begin
            rdata[LOCK_LOSS_BIT]     = lock_loss_q;
            rdata[LOCKED_BIT]        = locked_q;
            rdata[EXT_LOST_BIT]      = ext_lost_q;
            rdata[MODE_LSB +: 4]     = mode_q;
         end
         default:    rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= PSEL && PENABLE && !pready_q;
         pslverr_q <= PSEL && PENABLE && !pready_q && !rd_hit;
         prdata_q  <= (PSEL && PENABLE && !pready_q && !PWRITE) ? rdata : 32'h0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctrl1_q <= RST_CTRL1;
         ctrl2_q <= RST_CTRL2;
         ctrl3_q <= RST_CTRL3;
         trim_q  <= RST_TRIM;
      end else if (wr_en) begin
         case (PADDR)
            OFF_CTRL1: ctrl1_q <= PWDATA[7:0];
            OFF_CTRL2: ctrl2_q <= PWDATA[7:0];
            OFF_CTRL3: ctrl3_q <= PWDATA[7:0];
            OFF_TRIM:  trim_q  <= PWDATA[TRIM_W-1:0];
            default:   ctrl1_q <= ctrl1_q;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all internal connections
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         LOSS_RESET_REQ <= 1'b0;
         LOCK_IRQ       <= 1'b0;
      end else begin
         LOSS_RESET_REQ <= ext_lost_q;
         LOCK_IRQ       <= lock_loss_q && lock_ie;
      end
   end

   assign PRDATA        = prdata_q;
   assign PREADY        = pready_q;
   assign PSLVERR       = pslverr_q;
   assign SYS_CLK_EN    = bus_div.tick_out;
   assign REF_DIV_TICK  = ref_div.tick_out;
   assign DEBUG_CLK_OUT = dbg_q;
   assign INT_REF_OUT   = int_out_q;
   assign INT_REF_RUN   = int_run_q;
   assign TRIM          = trim_q;
   assign PLL_SELECT    = pll_sel;
   assign LOOP_ENABLE   = loop_en_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_src_route;
      @(posedge MCLK) disable iff (RST)
         (!STOP_REQ && src_sel == SRC_INT && INT_REF_TICK) |-> bus_div.tick_in;
   endproperty
   a_src_route: assert property (p_src_route) else $error("internal source not routed");

   property p_rsvd_code;
      @(posedge MCLK) disable iff (RST)
         (!STOP_REQ && src_sel == SRC_RSVD) |-> bus_div.tick_in == DCO_TICK;
   endproperty
   a_rsvd_code: assert property (p_rsvd_code) else $error("reserved code not as loop");

   property p_ref_select;
      @(posedge MCLK) disable iff (RST)
         ref_sel |-> ref_div.tick_in == INT_REF_TICK;
   endproperty
   a_ref_select: assert property (p_ref_select) else $error("reference select wrong");

   property p_int_out_gate;
      @(posedge MCLK) disable iff (RST) INT_REF_OUT |-> $past(int_out_en) && $past(INT_REF_TICK);
   endproperty
   a_int_out_gate: assert property (p_int_out_gate) else $error("internal output not gated");

   property p_stop_keep;
      @(posedge MCLK) disable iff (RST)
         (STOP_REQ && int_stop_en && int_out_en) [*2] |=> INT_REF_RUN;
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("internal reference dropped in stop");

   property p_stop_off;
      @(posedge MCLK) disable iff (RST) (STOP_REQ && !int_stop_en) |=> !INT_REF_RUN;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("internal reference kept in stop");

   sequence s_dco_pair;
      DCO_TICK && !dbg_phase_q ##1 !DCO_TICK ##1 DCO_TICK;
   endsequence
   property p_debug_half;
      @(posedge MCLK) disable iff (RST) s_dco_pair |=> DEBUG_CLK_OUT;
   endproperty
   a_debug_half: assert property (p_debug_half) else $error("debug clock not half rate");

   property p_monitor;
      @(posedge MCLK) disable iff (RST)
         (mon_expire && ext_in_use && !EXT_REF_TICK && !STOP_REQ) |-> ##2 LOSS_RESET_REQ;
   endproperty
   a_monitor: assert property (p_monitor) else $error("lost reference not reported");

   property p_lock_clear;
      @(posedge MCLK) disable iff (RST) (w1c_lock && !lock_event) |=> !lock_loss_q;
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock loss not cleared");

   property p_bus_reset;
      @(posedge MCLK) $past(RST) |-> ctrl2_q[BUS_DIV_LSB +: 2] == 2'h1 && ctrl1_q[5:3] == 3'h0;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("divider reset value wrong");

endmodule // clock_generator_unit
`default_nettype wire

// ### rtl/clock_generator_unit_pkg.sv
// Package of the clock generator unit: register map, field layout,
// reset values, source codes, operating modes and monitor timing.
// Assumes a 200 MHz block clock and an APB register bus with 32-bit data.
package clock_generator_unit_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL1  = 8'h00;
   localparam logic [7:0] OFF_CTRL2  = 8'h04;
   localparam logic [7:0] OFF_TRIM   = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_CTRL3  = 8'h10;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int SRC_SEL_LSB    = 6;
   localparam int REF_DIV_LSB    = 3;
   localparam int REF_SEL_BIT    = 2;
   localparam int INT_OUT_EN_BIT = 1;
   localparam int INT_STOP_EN_BIT = 0;
   localparam int BUS_DIV_LSB    = 6;
   localparam int LOW_POWER_BIT  = 3;
   localparam int PLL_SEL_BIT    = 0;
   localparam int LOCK_DET_BIT   = 1;
   localparam int LOCK_IE_BIT    = 2;
   localparam int MON_EN_BIT     = 3;
   localparam int LOCK_LOSS_BIT  = 7;
   localparam int LOCKED_BIT     = 6;
   localparam int EXT_LOST_BIT   = 5;
   localparam int MODE_LSB       = 0;
   localparam int TRIM_W         = 9;
   localparam int DIV_CODE_W     = 3;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]        RST_CTRL1 = 8'h04;
   localparam logic [7:0]        RST_CTRL2 = 8'h40;
   localparam logic [TRIM_W-1:0] RST_TRIM  = 9'h100;
   localparam logic [7:0]        RST_CTRL3 = 8'h00;

   // ------------------------------------------------------------------
   // System clock source codes
   // ------------------------------------------------------------------
   localparam logic [1:0] SRC_LOOP = 2'h0;
   localparam logic [1:0] SRC_INT  = 2'h1;
   localparam logic [1:0] SRC_EXT  = 2'h2;
   localparam logic [1:0] SRC_RSVD = 2'h3;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int MCLK_MHZ        = 200;
   localparam int MON_TIMEOUT_NS  = 20000;
   localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS * MCLK_MHZ) / 1000;
   localparam int MON_CNT_W       = 13;

   typedef enum logic [3:0] {
      fll_engaged_int_mode,
      fll_engaged_ext_mode,
      fll_bypassed_int_mode,
      fll_bypassed_ext_mode,
      pll_engaged_ext_mode,
      pll_bypassed_ext_mode,
      lowpower_int_mode,
      lowpower_ext_mode,
      stop_mode
   } mode_e;

endpackage

// ### rtl/tick_div_if.sv
// Carrier between the clock generator top and its pulse dividers.
// Assumes both ends run on the same block clock.
`timescale 1ns/10ps
`default_nettype none
interface tick_div_if;
   import clock_generator_unit_pkg::*;
   logic                  tick_in;
   logic [DIV_CODE_W-1:0] log2_ratio;
   logic                  tick_out;
   modport src (output tick_in, output log2_ratio, input tick_out);
   modport div (input tick_in, input log2_ratio, output tick_out);
endinterface
`default_nettype wire

// ### rtl/tick_divider.sv
// Power-of-two divider of a one-cycle tick stream.
// Assumes ticks are enable pulses on the block clock.
`timescale 1ns/10ps
`default_nettype none
module tick_divider
   import clock_generator_unit_pkg::*;
#(
   parameter int CNT_W = 7
) (
   // Clock and reset
   input  wire logic MCLK,
   input  wire logic RST,
   // Tick stream
   tick_div_if.div   dv
);
   logic [CNT_W-1:0]      cnt_q;
   logic [DIV_CODE_W-1:0] active_q;
   logic                  out_q;
   logic                  wrap;

   // Wrap when all selected low bits are set
   assign wrap = ((cnt_q | ~((CNT_W'(1) << active_q) - CNT_W'(1))) == {CNT_W{1'b1}});

   // ------------------------------------------------------------------
   // Counter; a new ratio is adopted only at a wrap so no short period
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cnt_q    <= '0;
         active_q <= '0;
         out_q    <= 1'b0;
      end else begin
         out_q <= dv.tick_in && wrap;
         if (dv.tick_in) begin
            if (wrap) begin
               cnt_q    <= '0;
               active_q <= dv.log2_ratio;
            end else begin
               cnt_q <= cnt_q + CNT_W'(1);
            end
         end
      end
   end

   assign dv.tick_out = out_q;

   property p_out_after_tick;
      @(posedge MCLK) disable iff (RST) out_q |-> $past(dv.tick_in);
   endproperty
   a_out_after_tick: assert property (p_out_after_tick) else $error("divided tick without input");

   property p_ratio_at_wrap;
      @(posedge MCLK) disable iff (RST) !$stable(active_q) |-> cnt_q == '0 && $past(wrap);
   endproperty
   a_ratio_at_wrap: assert property (p_ratio_at_wrap) else $error("ratio changed mid period");

endmodule // tick_divider
`default_nettype wire

// ### bench/tick_source.sv
// Far-side clock sources: oscillator core, internal and external
// references, each a one-cycle tick on MCLK.
// Assumes MCLK and RST are those of the block under test.
`timescale 1ns/10ps
`default_nettype none
module tick_source (
   // Clock and reset
   input  wire logic MCLK,
   input  wire logic RST,
   // External reference alive
   input  wire logic ext_run,
   // Ticks
   output logic      dco_tick,
   output logic      int_tick,
   output logic      ext_tick
);
   logic [3:0] cnt_q;
   always_ff @(posedge MCLK) begin
      if (RST || cnt_q == 4'hb) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // Periods 2, 3 and 4; a failed reference simply stops ticking
   always_ff @(posedge MCLK) begin
      dco_tick <= !RST && !cnt_q[0];
      int_tick <= !RST && (cnt_q % 4'h3 == 4'h0);
      ext_tick <= !RST && ext_run && (cnt_q[1:0] == 2'h0);
   end
endmodule // tick_source
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the clock generator unit over APB.
// Assumes the tick_source model feeds all three clock ticks.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import clock_generator_unit_pkg::*;
   logic MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, r;
   logic PREADY, PSLVERR, STOP_REQ = 1'b0, LOOP_LOCKED = 1'b1, ext_run = 1'b1;
   logic SYS_CLK_EN, DEBUG_CLK_OUT, INT_REF_OUT, REF_DIV_TICK, INT_REF_RUN;
   logic PLL_SELECT, LOOP_ENABLE, LOSS_RESET_REQ, LOCK_IRQ, e, oscillator_core, itk, etk;
   logic [TRIM_W-1:0] TRIM;
   logic [1:0] tsel = 2'h0, osel = 2'h0;
   int failures = 0, compares = 0, n, c;
   wire logic tk = (tsel == 2'h0) ? oscillator_core : (tsel == 2'h1) ? itk : etk;
   wire logic ot = (osel == 2'h0) ? SYS_CLK_EN : (osel == 2'h1) ? REF_DIV_TICK :
                   (osel == 2'h2) ? DEBUG_CLK_OUT : INT_REF_OUT;
   clock_generator_unit clock_generator_unit_inst (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .INT_REF_TICK(itk), .EXT_REF_TICK(etk),
      .DCO_TICK(oscillator_core), .LOOP_LOCKED(LOOP_LOCKED), .STOP_REQ(STOP_REQ),
      .SYS_CLK_EN(SYS_CLK_EN), .DEBUG_CLK_OUT(DEBUG_CLK_OUT), .INT_REF_OUT(INT_REF_OUT),
      .REF_DIV_TICK(REF_DIV_TICK), .INT_REF_RUN(INT_REF_RUN), .TRIM(TRIM),
      .PLL_SELECT(PLL_SELECT), .LOOP_ENABLE(LOOP_ENABLE), .LOSS_RESET_REQ(LOSS_RESET_REQ),
      .LOCK_IRQ(LOCK_IRQ));
   tick_source tick_source_inst (.MCLK(MCLK), .RST(RST), .ext_run(ext_run),
      .dco_tick(oscillator_core), .int_tick(itk), .ext_tick(etk));
   initial begin
      forever #2.5 MCLK = ~MCLK;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      @(posedge MCLK);
      while (PREADY !== 1'b1 && k < 50) begin
         @(posedge MCLK);
         k++;
      end
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (k == 50) failures++;
   endtask
   // Counts outputs lagging n source ticks by one cycle
   task automatic win(input int t);
      n = 0;
      c = 0;
      @(negedge MCLK);
      while (n < t) begin
         n += int'(tk);
         @(negedge MCLK);
         c += int'(ot);
      end
   endtask
   task automatic results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      apb(0, OFF_CTRL1, 0); check(r, 32'h04);
      apb(0, OFF_CTRL2, 0); check(r, 32'h40);
      apb(0, 8'h14, 0); check({r[30:0], e}, 32'h1);
      apb(1, OFF_TRIM, 32'h1a5);
      @(negedge MCLK);
      check(32'(TRIM), 32'h1a5);
   endtask
   task automatic t_refdiv;
      osel = 2'h1;
      tsel = 2'h1;
      for (int k = 0; k < 8; k++) begin
         apb(1, OFF_CTRL1, 32'h04 | (k << 3));
         win(256);
         win(256); check(c, 256 >> k);
      end
      tsel = 2'h2;
      apb(1, OFF_CTRL1, 32'h08);
      win(64);
      win(64); check(c, 32);
   endtask
   task automatic t_source;
      osel = 2'h0;
      for (int s = 0; s < 4; s++) begin
         tsel = (s == 3) ? 2'h0 : 2'(s);
         apb(1, OFF_CTRL1, 32'h04 | (s << 6));
         apb(1, OFF_CTRL2, s << 6);
         win(64);
         win(64); check(c, 64 >> s);
      end
      osel = 2'h2;
      tsel = 2'h0;
      win(64); check(c, 32);
      osel = 2'h3;
      tsel = 2'h1;
      apb(1, OFF_CTRL1, 32'h06);
      win(30); check(c, 30);
      apb(1, OFF_CTRL1, 32'h04);
      win(30); check(c, 0);
   endtask
   task automatic t_stop;
      osel = 2'h0;
      tsel = 2'h0;
      @(posedge MCLK);
      STOP_REQ <= 1'b1;
      for (n = 0; n < 20 && INT_REF_RUN !== 1'b0; n++) @(negedge MCLK);
      check(INT_REF_RUN, 0);
      check(LOOP_ENABLE, 0);
      apb(0, OFF_STATUS, 0); check(r & 32'hf, 8);
      win(16); check(c, 0);
      // Output enable, then internal-mode retention, then external mode
      for (int k = 0; k < 3; k++) begin
         @(posedge MCLK);
         STOP_REQ <= 1'b0;
         apb(1, OFF_CTRL1, (k == 0) ? 32'h07 : (k == 1) ? 32'h05 : 32'h01);
         // Let the mode settle so the pre-stop mode is the new one
         repeat (3) @(posedge MCLK);
         STOP_REQ <= 1'b1;
         win(16); check(INT_REF_RUN, k < 2);
      end
      @(posedge MCLK);
      STOP_REQ <= 1'b0;
      apb(1, OFF_CTRL1, 32'h44);
      apb(1, OFF_CTRL2, 32'h08);
      apb(0, OFF_STATUS, 0); check(r & 32'hf, 6);
      check(LOOP_ENABLE, 0);
   endtask
   task automatic t_lock;
      apb(1, OFF_CTRL3, 32'h07);
      // Lock must be seen before it can be lost
      repeat (2) @(posedge MCLK);
      check(PLL_SELECT, 1);
      LOOP_LOCKED <= 1'b0;
      apb(0, OFF_STATUS, 0); check(r[7], 1);
      check(LOCK_IRQ, 1);
      LOOP_LOCKED <= 1'b1;
      apb(1, OFF_STATUS, 0);
      apb(0, OFF_STATUS, 0); check(r[7], 1);
      apb(1, OFF_STATUS, 32'h80);
      apb(0, OFF_STATUS, 0); check({r[7], LOCK_IRQ}, 0);
   endtask
   task automatic t_monitor;
      apb(1, OFF_CTRL1, 32'h00);
      apb(1, OFF_CTRL3, 32'h08);
      ext_run <= 1'b0;
      for (n = 0; n < 4100 && LOSS_RESET_REQ !== 1'b1; n++) @(negedge MCLK);
      check(n > 3990 && n < 4010, 1);
   endtask
   initial begin
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      t_regs;
      t_refdiv;
      t_source;
      t_stop;
      t_lock;
      t_monitor;
      results;
   end
   initial begin
      #300000;
      failures++;
      results;
   end
endmodule // testbench
`default_nettype wire
